// ===== mode_sequencer.sv
// Power-mode state machine: Sleep, Stop, Software Flash and Restart
`timescale 1ns/100ps
`default_nettype none
module mode_sequencer (
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	input wire mode_pkg::host_cmd_s host_cmd,
	input wire logic status_read,
	input wire logic wake_read,
	input wire logic [mode_pkg::WAKE_W-2:0] wake_events,
	input wire logic wd_tick,
	input wire logic wd_fail,
	input wire logic undervoltage,
	input wire logic ext_reset_low,
	input wire logic test_pin,
	input wire logic [2:0] config_sel,
	output mode_pkg::host_status_s host_status,
	output logic host_reset_out_n,
	output logic host_interrupt_n,
	output logic fallback_output,
	output logic main_supply_enable,
	output logic [1:0] secondary_supply_enables,
	output logic watchdog_active,
	output logic [mode_pkg::PER_W-1:0] watchdog_period_out,
	output logic reception_enable,
	output logic slope_control_enable,
	output logic dev_mode
);
	import mode_pkg::*;

	// =========================================
	// State record
	typedef struct packed {
		mode_e mode;
		logic dev_mode;
		logic strap_taken;
		logic [WAKE_W-1:0] wake_en;
		logic periodic_en;
		logic wd_en;
		logic [PER_W-1:0] wd_period;
		logic reset_delay_long;
		logic [1:0] sec_en;
		logic fallback;
		logic fallback_cmd;
		logic [1:0] rm_bits;
		logic [2:0] lh_bits;
		logic [WAKE_W-1:0] wake_status;
		logic from_sleep;
		logic illegal_cmd;
		logic wd_miss;
		logic ack_pending;
		logic irq_n;
		logic rst_n;
		logic hold_start;
		logic main_en;
		logic wd_act;
		logic rx_en;
		logic slope_en;
	} seq_state_s;

	seq_state_s s_reg;
	seq_state_s s_next;
	logic hold_done;
	logic per_expired;
	logic [WAKE_W-1:0] wake_now;

	// Second-failure configs need two misses; wd_miss is cleared only on fail-safe exit
	function automatic logic needs_second(input logic [2:0] cfg);
		needs_second = (cfg == CFG_3) || (cfg == CFG_4);
	endfunction

	// Configs that cut supply and go fail-safe
	function automatic logic cuts_supply(input logic [2:0] cfg);
		cuts_supply = (cfg == CFG_2) || (cfg == CFG_4);
	endfunction

	// =========================================
	// Submodules
	hold_timer u_hold (
		.clock(clock),
		.reset(reset),
		.enable(clock_enable),
		.start(s_reg.hold_start),
		.long_sel(s_reg.reset_delay_long),
		.done(hold_done)
	);

	periodic_timer u_periodic (
		.clock(clock),
		.reset(reset),
		.enable(clock_enable),
		.run(s_reg.mode == st_stop && s_reg.periodic_en),
		.wd_tick(wd_tick),
		.period(s_reg.wd_period),
		.expired(per_expired)
	);

	// Enabled wake sources, periodic one included
	assign wake_now = {per_expired, wake_events} & s_reg.wake_en;

	// =========================================
	// Next-state logic
	always_comb begin
		s_next = s_reg;
		s_next.hold_start = 1'b0;
		// Interrupt line returns high unless set this cycle
		s_next.irq_n = 1'b1;
		if (!s_reg.strap_taken) begin
			s_next.strap_taken = 1'b1;
			s_next.dev_mode = !test_pin;
		end
		// Status read clears latched reasons, set wins over clear
		if (status_read) begin
			s_next.rm_bits = RM_NONE;
			s_next.lh_bits = LH_NONE;
			s_next.from_sleep = 1'b0;
			s_next.illegal_cmd = 1'b0;
		end
		if (wake_read) begin
			s_next.wake_status = '0;
			s_next.ack_pending = 1'b0;
		end
		// Host configuration writes outside frozen modes
		if (host_cmd.write && (s_reg.mode == st_normal || s_reg.mode == st_init)) begin
			s_next.wake_en = host_cmd.wake_enables;
			s_next.periodic_en = host_cmd.periodic_wake_enable;
			s_next.wd_en = host_cmd.watchdog_enable;
			s_next.wd_period = host_cmd.watchdog_period;
			s_next.reset_delay_long = host_cmd.reset_delay_long;
		end
		if (host_cmd.write && s_reg.mode != st_restart) begin
			s_next.sec_en = host_cmd.secondary_supply_enables;
			s_next.fallback_cmd = host_cmd.fallback_drive;
		end
		unique case (s_reg.mode)
			st_init: begin
				if (host_cmd.write && host_cmd.mode_select_field == CMD_NORMAL) begin
					s_next.mode = st_normal;
				end else if (host_cmd.write && host_cmd.mode_select_field == CMD_FLASH) begin
					s_next.mode = st_flash;
				end
			end
			st_normal: begin
				s_next.fallback = s_reg.fallback | host_cmd.write & host_cmd.fallback_drive;
				if (host_cmd.write) begin
					unique case (host_cmd.mode_select_field)
						CMD_SLEEP: begin
							if (host_cmd.wake_enables == '0) begin
								s_next.illegal_cmd = 1'b1;
								s_next.irq_n = 1'b0;
							end else begin
								s_next.mode = st_sleep;
								s_next.wd_en = 1'b0;
								s_next.wd_period = '0;
							end
						end
						CMD_STOP: begin
							if (!host_cmd.watchdog_enable && host_cmd.wake_enables == '0) begin
								s_next.illegal_cmd = 1'b1;
								s_next.wd_en = s_reg.wd_en;
								s_next.wd_period = s_reg.wd_period;
							end else begin
								s_next.mode = st_stop;
								s_next.wd_en = s_reg.wd_en;
								s_next.wd_period = s_reg.wd_period;
							end
						end
						CMD_FLASH: begin
							s_next.mode = st_flash;
							s_next.wd_en = s_reg.wd_en;
							s_next.wd_period = s_reg.wd_period;
							s_next.rst_n = 1'b0;
							s_next.hold_start = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			st_sleep: begin
				if (wake_now != '0) begin
					s_next.mode = st_restart;
					s_next.wake_status = wake_now;
					s_next.from_sleep = 1'b1;
					s_next.rst_n = 1'b0;
					s_next.hold_start = 1'b1;
				end
			end
			st_stop: begin
				if (wake_now != '0) begin
					s_next.irq_n = 1'b0;
					s_next.wake_status = s_next.wake_status | wake_now;
				end
				if (per_expired && s_reg.periodic_en) begin
					s_next.irq_n = 1'b0;
					s_next.ack_pending = 1'b1;
					if (s_reg.wd_en && s_reg.ack_pending && !wake_read) begin
						s_next.mode = st_restart;
						s_next.rm_bits = RM_WD_OR_CMD;
						s_next.rst_n = 1'b0;
						s_next.hold_start = 1'b1;
					end
				end
				if (host_cmd.write && host_cmd.mode_select_field == CMD_NORMAL) begin
					s_next.mode = st_normal;
				end
			end
			st_flash: begin
				// Flash on an incoming reset pulse releases once hold ends
				if (hold_done) begin
					s_next.rst_n = 1'b1;
				end
				s_next.fallback = s_reg.fallback | s_reg.fallback_cmd;
				if (host_cmd.write && host_cmd.mode_select_field == CMD_RESTART) begin
					s_next.mode = st_restart;
					s_next.rm_bits = RM_WD_OR_CMD;
					s_next.rst_n = 1'b0;
					s_next.hold_start = 1'b1;
				end
			end
			st_restart: begin
				if (hold_done) begin
					s_next.mode = st_normal;
					s_next.rst_n = 1'b1;
				end
			end
			st_failsafe: begin
				if (wake_events != '0) begin
					s_next.mode = st_restart;
					s_next.lh_bits = LH_FAILSAFE;
					s_next.wd_miss = 1'b0;
					s_next.rst_n = 1'b0;
					s_next.hold_start = 1'b1;
				end
			end
			default: begin
				s_next.mode = st_init;
			end
		endcase
		// Watchdog failure handling by configuration
		if (wd_fail && !s_reg.dev_mode && s_reg.wd_en
			&& (s_reg.mode == st_normal || s_reg.mode == st_stop
			|| s_reg.mode == st_flash)) begin
			s_next.rst_n = 1'b0;
			s_next.hold_start = 1'b1;
			if (s_reg.mode == st_flash) begin
				s_next.mode = st_restart;
				s_next.rm_bits = RM_WD_OR_CMD;
			end else if (needs_second(config_sel) && !s_reg.wd_miss) begin
				s_next.wd_miss = 1'b1;
				s_next.mode = st_restart;
				s_next.rm_bits = RM_WD_OR_CMD;
			end else if (cuts_supply(config_sel)) begin
				s_next.mode = st_failsafe;
				s_next.fallback = 1'b1;
				s_next.lh_bits = LH_FAILSAFE;
			end else begin
				s_next.mode = st_restart;
				s_next.fallback = 1'b1;
				s_next.lh_bits = LH_WD_FAIL;
			end
		end
		// Undervoltage reset from Normal, Stop or Flash
		if (undervoltage && (s_reg.mode == st_normal || s_reg.mode == st_stop
			|| s_reg.mode == st_flash)) begin
			s_next.mode = st_restart;
			s_next.rm_bits = RM_UNDERVOLT;
			s_next.rst_n = 1'b0;
			s_next.hold_start = 1'b1;
		end
		// External reset pulled low wins in any awake mode except Restart
		if (ext_reset_low && s_reg.main_en && s_reg.mode != st_restart) begin
			s_next.mode = st_restart;
			s_next.rm_bits = RM_EXT_RESET;
			s_next.rst_n = 1'b0;
			s_next.hold_start = 1'b1;
		end
		// Supplies follow the mode; fallback is never cleared here
		s_next.main_en = !(s_next.mode == st_sleep || s_next.mode == st_failsafe);
		if (s_next.mode == st_sleep || s_next.mode == st_failsafe) begin
			s_next.sec_en = '0;
		end
		if (s_next.mode == st_normal && s_reg.mode != st_normal) begin
			s_next.wd_miss = s_reg.wd_miss;
		end
		s_next.fallback = s_next.fallback | s_reg.fallback;
		// Decoded outputs registered together with the mode they follow
		s_next.wd_act = s_next.wd_en && s_next.mode != st_sleep;
		s_next.rx_en = s_next.mode == st_normal || s_next.mode == st_flash;
		s_next.slope_en = s_next.mode != st_flash;
	end

	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.mode <= st_init;
			s_reg.irq_n <= 1'b1;
			s_reg.rst_n <= 1'b0;
			s_reg.hold_start <= 1'b1;
			s_reg.main_en <= 1'b1;
			s_reg.slope_en <= 1'b1;
			s_reg.periodic_en <= 1'b0;
		end else if (clock_enable) begin
			s_reg <= s_next;
		end
	end

	// Init keeps reset low; only a hold ending in Restart or Flash releases it
	// =========================================
	// Outputs, all from the state register
	assign host_status = '{mode: s_reg.mode, restart_reason_bits: s_reg.rm_bits,
		fallback_reason_bits: s_reg.lh_bits, wake_status: s_reg.wake_status,
		from_sleep: s_reg.from_sleep, illegal_cmd: s_reg.illegal_cmd};
	assign host_reset_out_n = s_reg.rst_n;
	assign host_interrupt_n = s_reg.irq_n;
	assign fallback_output = s_reg.fallback;
	assign main_supply_enable = s_reg.main_en;
	assign secondary_supply_enables = s_reg.sec_en;
	assign watchdog_active = s_reg.wd_act;
	assign watchdog_period_out = s_reg.wd_period;
	assign reception_enable = s_reg.rx_en;
	assign slope_control_enable = s_reg.slope_en;
	assign dev_mode = s_reg.dev_mode;
endmodule
`default_nettype wire

// ===== mode_pkg.sv
// Shared types and constants for the power-mode sequencer
package mode_pkg;

	// =========================================
	// Operating modes (Gray codes along Init -> Normal -> Stop -> Sleep -> Restart -> Flash -> Failsafe)
	typedef enum logic [2:0] {
		st_init = 3'h0,
		st_normal = 3'h1,
		st_stop = 3'h3,
		st_sleep = 3'h2,
		st_restart = 3'h6,
		st_flash = 3'h7,
		st_failsafe = 3'h5
	} mode_e;

	// =========================================
	// Mode-select command codes
	localparam logic [2:0] CMD_NORMAL = 3'h0;
	localparam logic [2:0] CMD_SLEEP = 3'h1;
	localparam logic [2:0] CMD_STOP = 3'h2;
	localparam logic [2:0] CMD_FLASH = 3'h3;
	localparam logic [2:0] CMD_RESTART = 3'h4;

	// =========================================
	// Restart reason codes
	localparam logic [1:0] RM_NONE = 2'h0;
	localparam logic [1:0] RM_UNDERVOLT = 2'h1;
	localparam logic [1:0] RM_EXT_RESET = 2'h2;
	localparam logic [1:0] RM_WD_OR_CMD = 2'h3;
	// Fallback reason codes
	localparam logic [2:0] LH_NONE = 3'h0;
	localparam logic [2:0] LH_WD_FAIL = 3'h1;
	localparam logic [2:0] LH_FAILSAFE = 3'h2;

	// Configurations
	localparam logic [2:0] CFG_1 = 3'h1;
	localparam logic [2:0] CFG_2 = 3'h2;
	localparam logic [2:0] CFG_3 = 3'h3;
	localparam logic [2:0] CFG_4 = 3'h4;

	// Wake sources: bus, line, pin, periodic
	localparam int WAKE_W = 4;
	localparam int WAKE_PERIODIC = 3;

	// =========================================
	// Timing
	localparam int CLOCK_MHZ = 125;
	localparam int RESET_HOLD_SHORT_US = 10;
	localparam int RESET_HOLD_LONG_US = 20;
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] HOLD_SHORT_CYC = CNT_W'(RESET_HOLD_SHORT_US * CLOCK_MHZ);
	localparam logic [CNT_W-1:0] HOLD_LONG_CYC = CNT_W'(RESET_HOLD_LONG_US * CLOCK_MHZ);
	localparam int PER_W = 8;

	// =========================================
	// Host command group
	typedef struct packed {
		logic write;
		logic [2:0] mode_select_field;
		logic [WAKE_W-1:0] wake_enables;
		logic periodic_wake_enable;
		logic watchdog_enable;
		logic [PER_W-1:0] watchdog_period;
		logic reset_delay_long;
		logic fallback_drive;
		logic [1:0] secondary_supply_enables;
	} host_cmd_s;

	// Status group seen by host
	typedef struct packed {
		mode_e mode;
		logic [1:0] restart_reason_bits;
		logic [2:0] fallback_reason_bits;
		logic [WAKE_W-1:0] wake_status;
		logic from_sleep;
		logic illegal_cmd;
	} host_status_s;

endpackage

// ===== hold_timer.sv
// Reset-hold delay counter for the Restart mode
`timescale 1ns/100ps
`default_nettype none
module hold_timer (
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	input wire logic start,
	input wire logic long_sel,
	output logic done
);
	import mode_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic running;
		logic done;
	} hold_state_s;

	hold_state_s state_reg;
	hold_state_s state_next;

	// Load on start, count down, flag completion for one cycle
	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (start) begin
			state_next.count = long_sel ? HOLD_LONG_CYC : HOLD_SHORT_CYC;
			state_next.running = 1'b1;
		end else if (state_reg.running) begin
			if (state_reg.count <= CNT_W'(1)) begin
				state_next.running = 1'b0;
				state_next.done = 1'b1;
			end else begin
				state_next.count = state_reg.count - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= '0;
		end else if (enable) begin
			state_reg <= state_next;
		end
	end

	assign done = state_reg.done;
endmodule
`default_nettype wire

// ===== periodic_timer.sv
// Periodic wake-up timer driven by the watchdog time base
`timescale 1ns/100ps
`default_nettype none
module periodic_timer (
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	input wire logic run,
	input wire logic wd_tick,
	input wire logic [mode_pkg::PER_W-1:0] period,
	output logic expired
);
	import mode_pkg::*;

	typedef struct packed {
		logic [PER_W-1:0] count;
		logic expired;
	} per_state_s;

	per_state_s state_reg;
	per_state_s state_next;

	// Count watchdog ticks; pulse at each period end
	always_comb begin
		state_next = state_reg;
		state_next.expired = 1'b0;
		if (!run) begin
			state_next.count = '0;
		end else if (wd_tick) begin
			if (state_reg.count + PER_W'(1) >= period) begin
				state_next.count = '0;
				state_next.expired = 1'b1;
			end else begin
				state_next.count = state_reg.count + PER_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= '0;
		end else if (enable) begin
			state_reg <= state_next;
		end
	end

	assign expired = state_reg.expired;
endmodule
`default_nettype wire

// ===== host_model.sv
// Host microcontroller model: command strobes, status reads, interrupt acknowledge
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic clock,
	input wire logic host_interrupt_n,
	output var mode_pkg::host_cmd_s host_cmd,
	output logic status_read,
	output logic wake_read
);
	import mode_pkg::*;
	// =========================================
	// Host behaviour
	bit auto_ack = 0;
	int ack_delay = 2;
	initial begin
		host_cmd = '0;
		status_read = 1'b0;
		wake_read = 1'b0;
	end
	// One write strobe; fields show garbage once released
	task automatic send(input host_cmd_s c);
		@(posedge clock);
		#1;
		c.write = 1'b1;
		host_cmd = c;
		@(posedge clock);
		#1;
		c = ~c;
		c.write = 1'b0;
		host_cmd = c;
	endtask
	// Reads the reason bits once
	task automatic read_status();
		@(posedge clock);
		#1;
		status_read = 1'b1;
		@(posedge clock);
		#1;
		status_read = 1'b0;
	endtask
	// Acknowledges each interrupt by reading the wake register
	always @(posedge clock) begin
		if (auto_ack && host_interrupt_n === 1'b0) begin
			repeat (ack_delay) @(posedge clock);
			#1;
			wake_read = 1'b1;
			@(posedge clock);
			#1;
			wake_read = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== mode_sequencer_assertions.sv
// Port-level assertions for the power-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module mode_sequencer_assertions (
	input wire logic clock,
	input wire logic reset,
	input wire mode_pkg::host_cmd_s host_cmd,
	input wire logic wd_fail,
	input wire logic undervoltage,
	input wire logic ext_reset_low,
	input wire logic [2:0] config_sel,
	input wire logic dev_mode,
	input wire mode_pkg::host_status_s host_status,
	input wire logic host_reset_out_n,
	input wire logic host_interrupt_n,
	input wire logic fallback_output,
	input wire logic main_supply_enable,
	input wire logic watchdog_active,
	input wire logic reception_enable,
	input wire logic slope_control_enable
);
	import mode_pkg::*;
	// =========================================
	// Helper logic
	mode_e m;
	logic quiet;
	logic [12:0] rs_reg;
	logic [12:0] rs_next;
	assign m = host_status.mode;
	assign quiet = !wd_fail && !undervoltage && !ext_reset_low;
	// Counts consecutive cycles in Restart
	always_comb begin
		rs_next = (m == st_restart) ? rs_reg + 13'h1 : 13'h0;
	end
	always_ff @(posedge clock) begin
		rs_reg <= reset ? 13'h0 : rs_next;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// =========================================
	// Sequences and properties
	sequence s_leave_sleep;
		$past(m) == st_sleep && m != st_sleep;
	endsequence
	sequence s_leave_flash;
		$past(m) == st_flash && m != st_flash;
	endsequence
	sequence s_enter_flash;
		$past(m) == st_normal && m == st_flash;
	endsequence
	property p_sleep_off;
		m == st_sleep |-> !main_supply_enable && !watchdog_active;
	endproperty
	property p_sleep_exit;
		s_leave_sleep |-> m == st_restart;
	endproperty
	property p_sleep_refuse;
		m == st_normal && quiet && host_cmd.write && host_cmd.mode_select_field == CMD_SLEEP
			&& host_cmd.wake_enables == 4'h0 |=> m == st_normal && host_status.illegal_cmd
			##[0:1] !host_interrupt_n;
	endproperty
	property p_stop_main;
		m == st_stop |-> main_supply_enable;
	endproperty
	property p_flash_io;
		m == st_flash |-> reception_enable && !slope_control_enable;
	endproperty
	property p_flash_entry;
		s_enter_flash |-> ##[0:1] !host_reset_out_n;
	endproperty
	property p_flash_exit;
		s_leave_flash |-> m == st_restart;
	endproperty
	property p_restart_low;
		m == st_restart && $past(m) == st_restart |-> !host_reset_out_n;
	endproperty
	property p_restart_len;
		rs_reg <= 13'h9CE;
	endproperty
	property p_fb_kept;
		$fell(fallback_output) |-> m != st_restart && $past(m) != st_restart;
	endproperty
	property p_ext_reset;
		ext_reset_low && m == st_normal |=> m == st_restart && main_supply_enable
			&& host_status.restart_reason_bits == RM_EXT_RESET;
	endproperty
	property p_cfg2_fail;
		wd_fail && !undervoltage && !ext_reset_low && !dev_mode && config_sel == CFG_2
			&& watchdog_active
			&& m == st_normal |=> m == st_failsafe;
	endproperty
	// =========================================
	// Assertions
	a_sleep_off: assert property (p_sleep_off)
		else $error("supply or watchdog on in sleep");
	a_sleep_exit: assert property (p_sleep_exit)
		else $error("sleep left to a mode other than restart");
	a_sleep_refuse: assert property (p_sleep_refuse)
		else $error("sleep without wake source not refused");
	a_stop_main: assert property (p_stop_main)
		else $error("main supply off in stop");
	a_flash_io: assert property (p_flash_io)
		else $error("reception or slope wrong in flash");
	a_flash_entry: assert property (p_flash_entry)
		else $error("no host reset on flash entry");
	a_flash_exit: assert property (p_flash_exit)
		else $error("flash left to a mode other than restart");
	a_restart_low: assert property (p_restart_low)
		else $error("host reset high during restart");
	a_restart_len: assert property (p_restart_len)
		else $error("restart held too long");
	a_fb_kept: assert property (p_fb_kept)
		else $error("fallback dropped around restart");
	a_ext_reset: assert property (p_ext_reset)
		else $error("external reset not handled");
	a_cfg2_fail: assert property (p_cfg2_fail)
		else $error("configuration 2 failure not fail-safe");
endmodule
`default_nettype wire

// ===== tb_sbc_low_power_restart_modes.sv
// Self-checking bench for the power-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_sbc_low_power_restart_modes;
	import mode_pkg::*;
	// =========================================
	// Signals
	logic clock = 0;
	logic reset = 1;
	host_cmd_s hc;
	host_status_s st;
	logic status_read, wake_read, hrst_n, irq_n, fb, main_en, wd_act, rx_en, slope_en, dev;
	logic [1:0] sec_en;
	logic [PER_W-1:0] per_out;
	logic [2:0] wake_ev = 3'h0;
	logic wd_tick = 0, wd_fail = 0, uv = 0, ext_rst = 0;
	logic [2:0] cfg = CFG_1;
	int err_count = 0, checks = 0, irq = 0;
	initial begin
		forever #4 clock = ~clock;
	end
	mode_sequencer dut_u (
		.clock(clock), .reset(reset), .clock_enable(1'b1), .host_cmd(hc),
		.status_read(status_read), .wake_read(wake_read), .wake_events(wake_ev),
		.wd_tick(wd_tick), .wd_fail(wd_fail), .undervoltage(uv), .ext_reset_low(ext_rst),
		.test_pin(1'b1), .config_sel(cfg), .host_status(st), .host_reset_out_n(hrst_n),
		.host_interrupt_n(irq_n), .fallback_output(fb), .main_supply_enable(main_en),
		.secondary_supply_enables(sec_en), .watchdog_active(wd_act),
		.watchdog_period_out(per_out), .reception_enable(rx_en),
		.slope_control_enable(slope_en), .dev_mode(dev)
	);
	host_model host_u (
		.clock(clock), .host_interrupt_n(irq_n), .host_cmd(hc), .status_read(status_read),
		.wake_read(wake_read)
	);
	// Counts interrupt low cycles
	always @(posedge clock) begin
		if (irq_n === 1'b0) irq++;
	end
	// =========================================
	// Helpers
	task automatic cmp_bits(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_mode(input string nm, input mode_e e, input mode_e g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_mode(input mode_e m);
		int n;
		n = 0;
		while (st.mode !== m && n < 4000) begin
			tick(1);
			n++;
		end
		cmp_mode("mode", m, st.mode);
	endtask
	function automatic host_cmd_s mk(input logic [2:0] ms, input logic [3:0] we,
		input logic wd, input logic [7:0] per);
		host_cmd_s c;
		c = '0;
		c.mode_select_field = ms;
		c.wake_enables = we;
		c.watchdog_enable = wd;
		c.watchdog_period = per;
		c.periodic_wake_enable = we[WAKE_PERIODIC];
		return c;
	endfunction
	task automatic pulse_wd(input int k);
		repeat (k) begin
			wd_tick = 1'b1;
			tick(1);
			wd_tick = 1'b0;
			tick(3);
		end
	endtask
	// =========================================
	// Scenarios
	task automatic t_reset();
		cmp_mode("init mode", st_init, st.mode);
		cmp_bits("reset out", 8'h0, hrst_n);
		cmp_bits("fallback", 8'h0, fb);
		cmp_bits("dev mode", 8'h0, dev);
		host_u.send(mk(CMD_NORMAL, 4'h0, 1'b1, 8'h10));
		wait_mode(st_normal);
	endtask
	task automatic t_refuse();
		int i0;
		i0 = irq;
		host_u.send(mk(CMD_SLEEP, 4'h0, 1'b1, 8'h10));
		tick(2);
		cmp_mode("sleep refused", st_normal, st.mode);
		cmp_bits("illegal", 8'h1, st.illegal_cmd);
		cmp_bits("refusal irq", 8'h1, 8'(irq - i0));
		host_u.read_status();
		tick(1);
		cmp_bits("illegal read", 8'h0, st.illegal_cmd);
		host_u.send(mk(CMD_STOP, 4'h0, 1'b0, 8'h10));
		tick(2);
		cmp_mode("stop refused", st_normal, st.mode);
		cmp_bits("illegal stop", 8'h1, st.illegal_cmd);
		host_u.read_status();
	endtask
	task automatic t_sleep();
		int i0, n;
		host_u.send(mk(CMD_SLEEP, 4'h4, 1'b1, 8'h10));
		tick(1);
		cmp_mode("sleep", st_sleep, st.mode);
		cmp_bits("sleep supply", 8'h0, {main_en, wd_act});
		i0 = irq;
		wake_ev = 3'h4;
		wait_mode(st_restart);
		wake_ev = 3'h0;
		cmp_bits("restart reset", 8'h0, hrst_n);
		n = 0;
		while (st.mode === st_restart && n < 3000) begin
			tick(1);
			n++;
		end
		cmp_bits("hold", 8'h1, 8'(n > HOLD_SHORT_CYC - 4 && n < HOLD_SHORT_CYC + 4));
		cmp_mode("after hold", st_normal, st.mode);
		cmp_bits("released", 8'h1, hrst_n);
		cmp_bits("wake source", 8'h4, st.wake_status);
		cmp_bits("from sleep", 8'h1, st.from_sleep);
		cmp_bits("no wake irq", 8'h0, 8'(irq - i0));
		host_u.read_status();
	endtask
	task automatic t_stop();
		host_cmd_s c;
		int i0;
		c = mk(CMD_NORMAL, 4'h4, 1'b1, 8'h10);
		c.secondary_supply_enables = 2'h3;
		host_u.send(c);
		c.mode_select_field = CMD_STOP;
		host_u.send(c);
		tick(2);
		cmp_mode("stop", st_stop, st.mode);
		cmp_bits("stop supplies", 8'h7, {main_en, sec_en});
		host_u.send(mk(CMD_STOP, 4'h4, 1'b1, 8'h20));
		tick(2);
		cmp_bits("frozen period", 8'h10, per_out);
		i0 = irq;
		wake_ev = 3'h4;
		tick(1);
		wake_ev = 3'h0;
		tick(3);
		cmp_bits("stop wake irq", 8'h1, 8'(irq - i0));
		cmp_mode("stays stop", st_stop, st.mode);
		host_u.send(mk(CMD_NORMAL, 4'h4, 1'b1, 8'h10));
		wait_mode(st_normal);
	endtask
	task automatic t_periodic();
		int i0;
		host_u.send(mk(CMD_NORMAL, 4'h0, 1'b1, 8'h03));
		host_u.send(mk(CMD_NORMAL, 4'h8, 1'b1, 8'h03));
		host_u.send(mk(CMD_STOP, 4'h8, 1'b1, 8'h03));
		host_u.auto_ack = 1;
		tick(2);
		i0 = irq;
		pulse_wd(30);
		cmp_bits("periodic irq", 8'h1, 8'(irq - i0 > 5 && irq - i0 < 11));
		cmp_mode("acked stop", st_stop, st.mode);
		host_u.auto_ack = 0;
		pulse_wd(12);
		wait_mode(st_restart);
		wait_mode(st_normal);
		host_u.read_status();
	endtask
	task automatic t_flash();
		host_cmd_s c;
		int n;
		c = mk(CMD_NORMAL, 4'h0, 1'b1, 8'h10);
		c.fallback_drive = 1'b1;
		host_u.send(c);
		c.mode_select_field = CMD_FLASH;
		host_u.send(c);
		tick(2);
		cmp_mode("flash", st_flash, st.mode);
		cmp_bits("flash reset", 8'h0, hrst_n);
		cmp_bits("flash io", 8'h5, {rx_en, slope_en, fb});
		n = 0;
		while (hrst_n !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		host_u.send(mk(CMD_FLASH, 4'h0, 1'b1, 8'h40));
		tick(2);
		cmp_bits("flash period", 8'h10, per_out);
		uv = 1'b1;
		tick(1);
		uv = 1'b0;
		wait_mode(st_restart);
		cmp_bits("exit reset", 8'h0, hrst_n);
		cmp_bits("fb kept", 8'h1, fb);
		wait_mode(st_normal);
		cmp_bits("uv reason", RM_UNDERVOLT, st.restart_reason_bits);
		host_u.read_status();
		tick(1);
		cmp_bits("reason read", RM_NONE, st.restart_reason_bits);
	endtask
	task automatic t_ext_fail();
		ext_rst = 1'b1;
		tick(1);
		ext_rst = 1'b0;
		wait_mode(st_restart);
		cmp_bits("ext reason", RM_EXT_RESET, st.restart_reason_bits);
		cmp_bits("ext supply fb", 8'h3, {main_en, fb});
		wait_mode(st_normal);
		cfg = CFG_2;
		tick(1);
		wd_fail = 1'b1;
		tick(1);
		wd_fail = 1'b0;
		wait_mode(st_failsafe);
	endtask
	// =========================================
	// Run control
	task automatic conclude();
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		tick(16);
		reset = 1'b0;
		t_reset();
		t_refuse();
		t_sleep();
		t_stop();
		t_periodic();
		t_flash();
		t_ext_fail();
		conclude();
	end
	// Cuts a hang short
	initial begin
		repeat (60000) @(posedge clock);
		err_count++;
		conclude();
	end
endmodule
bind mode_sequencer mode_sequencer_assertions chk_u (
	.clock(clock), .reset(reset), .host_cmd(host_cmd), .wd_fail(wd_fail),
	.undervoltage(undervoltage), .ext_reset_low(ext_reset_low), .config_sel(config_sel),
	.dev_mode(dev_mode), .host_status(host_status), .host_reset_out_n(host_reset_out_n),
	.host_interrupt_n(host_interrupt_n), .fallback_output(fallback_output),
	.main_supply_enable(main_supply_enable), .watchdog_active(watchdog_active),
	.reception_enable(reception_enable), .slope_control_enable(slope_control_enable)
);
`default_nettype wire
